// >>> include/rnbsk_defines.svh
// Constants for the radio data-port block: timing, rates, slot widths.
// Assumes a 20 MHz system clock and a link chip clock of its own.
// Summary of operation
// - Shared slot width: 18 ms frequency hopping, 54 ms single channel.
// - Type 3 traffic gets slot offset zero, limit zero, no random delay.
// - Radio passes trailing flags unchanged; they count as data.
// - Data port is synchronous single-ended half-duplex NRZ.
// - Rates 600 to 16000 bps; slower rates repeated up to 16000 by majority.
// - Squelch asserts on any channel activity, voice or data; the code keeps it deasserted while its own keying is on.
// - Receive clock follows squelch, except plain-text 16000 bps: together.
// - Voice reception asserts squelch but withholds the receive clock.
`ifndef RNBSK_DEFINES_SVH
`define RNBSK_DEFINES_SVH

// ------------------------------------------------------------------
// Clock and timing
// ------------------------------------------------------------------
`define RNBSK_CLK_HZ      20000000
`define RNBSK_CLK_KHZ     20000
`define RNBSK_SLOT_FH_MS  18
`define RNBSK_SLOT_SC_MS  54
`define RNBSK_LEAD_US     1000
`define RNBSK_LEAD_CYC    (`RNBSK_LEAD_US * `RNBSK_CLK_HZ / 1000000)

// ------------------------------------------------------------------
// Data rates
// ------------------------------------------------------------------
`define RNBSK_BPS_600     600
`define RNBSK_BPS_1200    1200
`define RNBSK_BPS_2400    2400
`define RNBSK_BPS_4800    4800
`define RNBSK_BPS_16000   16000
`define RNBSK_RATE_600    3'h0
`define RNBSK_RATE_1200   3'h1
`define RNBSK_RATE_2400   3'h2
`define RNBSK_RATE_4800   3'h3
`define RNBSK_RATE_16000  3'h4

`endif

// >>> include/rnbsk_pkg.sv
// Types shared by the radio data-port block.
// Assumes rnbsk_defines.svh supplies the numeric constants.
package rnbsk_pkg;

   // Transmit keying states, Gray along idle -> wait -> send
   typedef enum logic [1:0] {
      RNBSK_TX_IDLE = 2'b00,
      RNBSK_TX_WAIT = 2'b01,
      RNBSK_TX_SEND = 2'b11
   } rnbsk_tx_state_t;

   // Quasi-static operating configuration
   typedef struct packed {
      logic [2:0] rate_sel;
      logic       frequency_hopping;
      logic       plain_text;
      logic       type3;
      logic [3:0] slot_offset;
      logic [3:0] slot_limit;
   } rnbsk_cfg_t;

endpackage : rnbsk_pkg

// >>> logic/rnbsk_sync.sv
// Two-flop level synchroniser, one per bit of a parameterised vector.
// Assumes each bit is a level or a slow toggle from another domain.
`timescale 1ns/1ns
module rnbsk_sync #(
   parameter int unsigned WIDTH = 1
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             arst_n,
   // Data
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);

   logic [WIDTH-1:0] meta;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         meta <= '0;
         q    <= '0;
      end else begin
         meta <= d;
         q    <= meta;
      end
   end

endmodule : rnbsk_sync

// >>> logic/rnbsk_top.sv
// Radio data port: keying with embedded access delay, NRZ bit clocking to
// the terminal, rate repetition on the air side, squelch and receive clock.
// Assumes air_clk is the radio's chip clock and cfg is held steady.
`timescale 1ns/1ns
`include "rnbsk_defines.svh"
module rnbsk_top
   import rnbsk_pkg::*;
#(
   parameter int unsigned HALF_600   = `RNBSK_CLK_HZ / (2 * `RNBSK_BPS_600),
   parameter int unsigned HALF_1200  = `RNBSK_CLK_HZ / (2 * `RNBSK_BPS_1200),
   parameter int unsigned HALF_2400  = `RNBSK_CLK_HZ / (2 * `RNBSK_BPS_2400),
   parameter int unsigned HALF_4800  = `RNBSK_CLK_HZ / (2 * `RNBSK_BPS_4800),
   parameter int unsigned HALF_16000 = `RNBSK_CLK_HZ / (2 * `RNBSK_BPS_16000),
   parameter int unsigned SLOT_FH    = `RNBSK_SLOT_FH_MS * `RNBSK_CLK_KHZ,
   parameter int unsigned SLOT_SC    = `RNBSK_SLOT_SC_MS * `RNBSK_CLK_KHZ,
   parameter int unsigned LEAD_CYC   = `RNBSK_LEAD_CYC
) (
   // System clock and reset
   input  wire logic       mclk,
   input  wire logic       arst_n,
   // Configuration
   input  wire rnbsk_cfg_t cfg,
   // Terminal side pins
   input  wire logic       dte_ptt,
   input  wire logic       dte_tx_data,
   output logic            dte_tx_clock,
   output logic            dte_rx_data,
   output logic            rx_data_clock_out,
   output logic            receive_squelch_n,
   // Air side, on the link clock
   input  wire logic       air_clk,
   input  wire logic       air_carrier,
   input  wire logic       air_rx_data_mode,
   input  wire logic       air_rx_chip,
   output logic            air_tx_data,
   output logic            air_tx_en
);

   // ------------------------------------------------------------------
   // Parameter checks
   // ------------------------------------------------------------------
   generate
      if (HALF_600 < 1 || HALF_600 > 65535 || HALF_16000 < 1 ||
          SLOT_FH < 1 || SLOT_SC < 1 || SLOT_SC > 2097151 ||
          SLOT_FH > 2097151 || LEAD_CYC > 2097151) begin : g_bad
         $error("rnbsk_top: parameter outside counter range");
      end
   endgenerate

   // ------------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------------
   localparam int unsigned REP_600  = `RNBSK_BPS_16000 / `RNBSK_BPS_600;
   localparam int unsigned REP_1200 = `RNBSK_BPS_16000 / `RNBSK_BPS_1200;
   localparam int unsigned REP_2400 = `RNBSK_BPS_16000 / `RNBSK_BPS_2400;
   localparam int unsigned REP_4800 = `RNBSK_BPS_16000 / `RNBSK_BPS_4800;

   rnbsk_tx_state_t tx_state;
   logic [1:0]      dte_s;
   logic [2:0]      air_s;
   logic [2:0]      mclk_s;
   logic            ptt_d;
   logic [15:0]     half_len;
   logic [4:0]      next_rep;
   logic [4:0]      rep_m;
   logic            cfg_tgl;
   logic [7:0]      lfsr;
   logic [20:0]     slot_cnt;
   logic [20:0]     slot_len;
   logic [4:0]      slots_left;
   logic [4:0]      next_delay;
   logic [15:0]     tclk_cnt;
   logic            tx_bit;
   logic            tx_tgl;
   logic            keyed;
   logic            busy;
   logic [20:0]     lead_cnt;
   logic            rclk_en;
   logic            rx_tgl_d;
   logic [15:0]     rclk_cnt;
   logic            rclk_wait;
   // Air domain
   logic            tx_tgl_d_a;
   logic            cfg_tgl_d_a;
   logic [4:0]      rep_a;
   logic [4:0]      chip_cnt;
   logic [4:0]      ones;
   logic            rx_bit;
   logic            rx_tgl;

   // ------------------------------------------------------------------
   // Synchronisers
   // ------------------------------------------------------------------
   rnbsk_sync #(.WIDTH(2)) u_sync_dte (
      .clk    (mclk),
      .arst_n (arst_n),
      .d      ({dte_ptt, dte_tx_data}),
      .q      (dte_s)
   );

   rnbsk_sync #(.WIDTH(3)) u_sync_air (
      .clk    (mclk),
      .arst_n (arst_n),
      .d      ({air_carrier, air_rx_data_mode, rx_tgl}),
      .q      (air_s)
   );

   rnbsk_sync #(.WIDTH(3)) u_sync_mclk (
      .clk    (air_clk),
      .arst_n (arst_n),
      .d      ({tx_tgl, keyed, cfg_tgl}),
      .q      (mclk_s)
   );

   // ------------------------------------------------------------------
   // Rate decode
   // ------------------------------------------------------------------
   always_comb begin
      unique case (cfg.rate_sel)
         `RNBSK_RATE_600: begin
            half_len = 16'(HALF_600);
            next_rep = 5'(REP_600);
         end
         `RNBSK_RATE_1200: begin
            half_len = 16'(HALF_1200);
            next_rep = 5'(REP_1200);
         end
         `RNBSK_RATE_2400: begin
            half_len = 16'(HALF_2400);
            next_rep = 5'(REP_2400);
         end
         `RNBSK_RATE_4800: begin
            half_len = 16'(HALF_4800);
            next_rep = 5'(REP_4800);
         end
         default: begin
            half_len = 16'(HALF_16000);
            next_rep = 5'h01;
         end
      endcase
   end

   // Rate change handed to the air side by toggle; rate must stay put
   // for a few link clocks after a change, as the word is not acked.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rep_m   <= 5'h01;
         cfg_tgl <= 1'b0;
      end else if (next_rep != rep_m) begin
         rep_m   <= next_rep;
         cfg_tgl <= ~cfg_tgl;
      end
   end

   // ------------------------------------------------------------------
   // Access delay and keying
   // ------------------------------------------------------------------
   assign slot_len   = cfg.frequency_hopping ? 21'(SLOT_FH) : 21'(SLOT_SC);
   assign next_delay = cfg.type3 ? 5'h00 :
                       5'({1'b0, cfg.slot_offset} +
                          5'(lfsr[3:0] % ({1'b0, cfg.slot_limit} + 5'h01)));

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         lfsr <= 8'h01;
      end else begin
         lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         tx_state   <= RNBSK_TX_IDLE;
         ptt_d      <= 1'b0;
         slot_cnt   <= 21'h000000;
         slots_left <= 5'h00;
      end else begin
         ptt_d <= dte_s[1];
         unique case (tx_state)
            RNBSK_TX_IDLE: begin
               if (dte_s[1] && !ptt_d) begin
                  slot_cnt   <= 21'h000000;
                  slots_left <= next_delay;
                  tx_state   <= (next_delay == 5'h00) ? RNBSK_TX_SEND : RNBSK_TX_WAIT;
               end
            end
            RNBSK_TX_WAIT: begin
               if (!dte_s[1]) begin
                  tx_state <= RNBSK_TX_IDLE;
               end else if (slot_cnt == slot_len - 21'h000001) begin
                  slot_cnt   <= 21'h000000;
                  slots_left <= slots_left - 5'h01;
                  if (slots_left == 5'h01) begin
                     tx_state <= RNBSK_TX_SEND;
                  end
               end else begin
                  slot_cnt <= slot_cnt + 21'h000001;
               end
            end
            RNBSK_TX_SEND: begin
               if (!dte_s[1]) begin
                  tx_state <= RNBSK_TX_IDLE;
               end
            end
            default: begin
               tx_state <= RNBSK_TX_IDLE;
            end
         endcase
      end
   end

   assign keyed = (tx_state == RNBSK_TX_SEND);

   // ------------------------------------------------------------------
   // Transmit bit clock to the terminal
   // ------------------------------------------------------------------
   // Every bit the terminal clocks in is carried, trailing flags included.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         dte_tx_clock <= 1'b1;
         tclk_cnt     <= 16'h0000;
         tx_bit       <= 1'b1;
         tx_tgl       <= 1'b0;
      end else if (!keyed) begin
         dte_tx_clock <= 1'b1;
         tclk_cnt     <= 16'h0000;
         tx_bit       <= 1'b1;
      end else if (tclk_cnt == half_len - 16'h0001) begin
         tclk_cnt     <= 16'h0000;
         dte_tx_clock <= ~dte_tx_clock;
         if (!dte_tx_clock) begin
            tx_bit <= dte_s[0];
            tx_tgl <= ~tx_tgl;
         end
      end else begin
         tclk_cnt <= tclk_cnt + 16'h0001;
      end
   end

   // ------------------------------------------------------------------
   // Squelch and receive clock
   // ------------------------------------------------------------------
   // Own transmission is not reported back: the port is half duplex.
   assign busy    = air_s[2] && !keyed;
   assign rclk_en = busy && air_s[1] &&
                    ((lead_cnt == 21'(LEAD_CYC)) ||
                     (cfg.plain_text && cfg.rate_sel == `RNBSK_RATE_16000));

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         receive_squelch_n <= 1'b1;
         lead_cnt          <= 21'h000000;
      end else begin
         receive_squelch_n <= ~busy;
         if (!busy) begin
            lead_cnt <= 21'h000000;
         end else if (lead_cnt != 21'(LEAD_CYC)) begin
            lead_cnt <= lead_cnt + 21'h000001;
         end
      end
   end

   // New bit presented with the clock low, clock raised half a bit later
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rx_tgl_d          <= 1'b0;
         dte_rx_data       <= 1'b1;
         rx_data_clock_out <= 1'b1;
         rclk_cnt          <= 16'h0000;
         rclk_wait         <= 1'b0;
      end else begin
         rx_tgl_d <= air_s[0];
         if (!rclk_en) begin
            rx_data_clock_out <= 1'b1;
            rclk_wait         <= 1'b0;
            dte_rx_data       <= 1'b1;
         end else if (air_s[0] != rx_tgl_d) begin
            dte_rx_data       <= rx_bit;
            rx_data_clock_out <= 1'b0;
            rclk_cnt          <= 16'h0000;
            rclk_wait         <= 1'b1;
         end else if (rclk_wait) begin
            if (rclk_cnt == half_len - 16'h0001) begin
               rx_data_clock_out <= 1'b1;
               rclk_wait         <= 1'b0;
            end else begin
               rclk_cnt <= rclk_cnt + 16'h0001;
            end
         end
      end
   end

   // ------------------------------------------------------------------
   // Air side: transmit hold, receive majority vote
   // ------------------------------------------------------------------
   always_ff @(posedge air_clk or negedge arst_n) begin
      if (!arst_n) begin
         cfg_tgl_d_a <= 1'b0;
         rep_a       <= 5'h01;
      end else begin
         cfg_tgl_d_a <= mclk_s[0];
         if (mclk_s[0] != cfg_tgl_d_a) begin
            rep_a <= rep_m;
         end
      end
   end

   // Each bit is held for its whole period, which repeats it per chip
   always_ff @(posedge air_clk or negedge arst_n) begin
      if (!arst_n) begin
         tx_tgl_d_a  <= 1'b0;
         air_tx_data <= 1'b1;
         air_tx_en   <= 1'b0;
      end else begin
         tx_tgl_d_a <= mclk_s[2];
         air_tx_en  <= mclk_s[1];
         if (!mclk_s[1]) begin
            air_tx_data <= 1'b1;
         end else if (mclk_s[2] != tx_tgl_d_a) begin
            air_tx_data <= tx_bit;
         end
      end
   end

   always_ff @(posedge air_clk or negedge arst_n) begin
      if (!arst_n) begin
         chip_cnt <= 5'h00;
         ones     <= 5'h00;
         rx_bit   <= 1'b1;
         rx_tgl   <= 1'b0;
      end else if (!(air_carrier && air_rx_data_mode && !mclk_s[1])) begin
         chip_cnt <= 5'h00;
         ones     <= 5'h00;
      end else if (chip_cnt == rep_a - 5'h01) begin
         chip_cnt <= 5'h00;
         ones     <= 5'h00;
         rx_bit   <= (6'({ones + 5'(air_rx_chip), 1'b0}) > {1'b0, rep_a});
         rx_tgl   <= ~rx_tgl;
      end else begin
         chip_cnt <= chip_cnt + 5'h01;
         ones     <= ones + 5'(air_rx_chip);
      end
   end

endmodule : rnbsk_top

// >>> tb/rnbsk_top_properties.sv
// Checker for the radio data port: keying delay, squelch, receive clock.
// Assumes the bench holds cfg and the air inputs steady across scenarios.
`timescale 1ns/1ns
module rnbsk_top_properties
   import rnbsk_pkg::*;
#(
   parameter int unsigned HALF_600 = 12,
   parameter int unsigned SLOT_FH  = 20,
   parameter int unsigned SLOT_SC  = 60
) (
   // Clocks and reset
   input wire logic       mclk,
   input wire logic       air_clk,
   input wire logic       arst_n,
   // Block inputs
   input wire rnbsk_cfg_t cfg,
   input wire logic       dte_ptt,
   input wire logic       dte_tx_data,
   input wire logic       air_carrier,
   input wire logic       air_rx_data_mode,
   input wire logic       air_rx_chip,
   // Block outputs
   input wire logic       dte_tx_clock,
   input wire logic       dte_rx_data,
   input wire logic       rx_data_clock_out,
   input wire logic       receive_squelch_n,
   input wire logic       air_tx_data,
   input wire logic       air_tx_en
);
   localparam int T3_MAX = HALF_600 + 8;
   logic        ptt_q;
   logic        started;
   logic [31:0] wait_cnt;
   logic [31:0] slot_len;
   assign slot_len = cfg.frequency_hopping ? SLOT_FH : SLOT_SC;
   // ----------------------------
   // Cycles since keying request
   // ----------------------------
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         ptt_q    <= 1'b0;
         wait_cnt <= 32'h0;
      end else begin
         ptt_q    <= dte_ptt;
         wait_cnt <= (dte_ptt && !ptt_q) ? 32'h0 : wait_cnt + 32'h1;
      end
   end
   // Only the first clock fall of a keying counts
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) started <= 1'b0;
      else started <= dte_ptt && (started || !dte_tx_clock);
   end
   AST_SLOT_WAIT: assert property (@(posedge mclk) disable iff (!arst_n)
      $fell(dte_tx_clock) && !started && !cfg.type3
      |-> wait_cnt >= 32'(cfg.slot_offset) * slot_len) else $error("keyed before slot wait");
   AST_TYPE3_NOW: assert property (@(posedge mclk) disable iff (!arst_n)
      $rose(dte_ptt) && cfg.type3 |-> ##[1:T3_MAX] !dte_tx_clock)
      else $error("type 3 keying delayed");
   AST_HALF_DUPLEX: assert property (@(posedge mclk) disable iff (!arst_n)
      !dte_tx_clock |-> receive_squelch_n) else $error("squelch while keyed");
   AST_SQ_ON: assert property (@(posedge mclk) disable iff (!arst_n)
      (air_carrier && !dte_ptt) [*8] |-> !receive_squelch_n) else $error("squelch missing");
   AST_SQ_OFF: assert property (@(posedge mclk) disable iff (!arst_n)
      (!air_carrier) [*8] |-> receive_squelch_n) else $error("squelch without carrier");
   AST_RXCLK_SQ: assert property (@(posedge mclk) disable iff (!arst_n)
      $fell(rx_data_clock_out) |-> !receive_squelch_n || !$past(receive_squelch_n, 6))
      else $error("receive clock without squelch");
   AST_VOICE_NOCLK: assert property (@(posedge mclk) disable iff (!arst_n)
      $fell(rx_data_clock_out) |-> $past(air_rx_data_mode, 2))
      else $error("receive clock during voice");
   AST_TX_IDLE: assert property (@(posedge mclk) disable iff (!arst_n)
      (!dte_ptt) [*6] |-> dte_tx_clock) else $error("transmit clock while unkeyed");
   AST_AIR_IDLE: assert property (@(posedge air_clk) disable iff (!arst_n)
      (!air_tx_en) [*6] |-> air_tx_data) else $error("air line not ones when idle");
   COV_RX_BIT: cover property (@(posedge mclk) disable iff (!arst_n) $fell(rx_data_clock_out));
   COV_KEYED: cover property (@(posedge air_clk) disable iff (!arst_n) $rose(air_tx_en));
   COV_VOICE: cover property (@(posedge mclk) disable iff (!arst_n)
      !receive_squelch_n && !air_rx_data_mode);
endmodule : rnbsk_top_properties

bind rnbsk_top rnbsk_top_properties #(
   .HALF_600(HALF_600), .SLOT_FH(SLOT_FH), .SLOT_SC(SLOT_SC)
) i_rnbsk_top_properties (
   .mclk, .air_clk, .arst_n, .cfg, .dte_ptt, .dte_tx_data, .air_carrier,
   .air_rx_data_mode, .air_rx_chip, .dte_tx_clock, .dte_rx_data,
   .rx_data_clock_out, .receive_squelch_n, .air_tx_data, .air_tx_en
);

// >>> tb/rnbsk_dte_model.sv
// Terminal stand-in: keys the radio, shifts a word out on its clock and
// decodes squelch and receive clock into a channel status.
// Assumes the radio takes each bit on the rising edge of dte_tx_clock.
`timescale 1ns/1ns
module rnbsk_dte_model #(
   parameter int VOICE_CYC = 100
) (
   // Bench control
   input  wire logic        key,
   input  wire logic [23:0] word,
   // Radio pins
   input  wire logic        mclk,
   input  wire logic        dte_tx_clock,
   input  wire logic        receive_squelch_n,
   input  wire logic        rx_data_clock_out,
   output logic             dte_ptt,
   output logic             dte_tx_data,
   // Channel status: 0 idle, 1 busy unknown, 2 data, 3 voice
   output logic [1:0]       rx_state,
   output logic             if_err
);
   int idx = 23;
   int busy_cyc = 0;
   initial dte_tx_data = 1'b1;
   assign dte_ptt = key;
   // Squelch alone must persist before voice is assumed; busy_cyc then holds
   // the busy-to-voice interval, VOICE_CYC, until squelch or the receive clock clears it.
   always @(posedge mclk) begin
      if_err <= (if_err === 1'b1) || (!rx_data_clock_out && receive_squelch_n);
      if (receive_squelch_n) begin
         rx_state <= 2'h0;
         busy_cyc <= 0;
      end else if (!rx_data_clock_out || rx_state == 2'h2) begin
         rx_state <= 2'h2;
         busy_cyc <= 0;
      end else if (busy_cyc >= VOICE_CYC) begin
         rx_state <= 2'h3;
      end else begin
         rx_state <= 2'h1;
         busy_cyc <= busy_cyc + 1;
      end
   end
   // Word opens with a flag, data only changes on the falling edge
   always @(negedge dte_tx_clock or negedge key) begin
      if (!key) begin
         idx = 23;
         dte_tx_data = 1'b1;
      end else begin
         dte_tx_data = word[idx];
         idx = (idx > 0) ? idx - 1 : 0;
      end
   end
endmodule : rnbsk_dte_model

// >>> tb/test_radio_net_busy_sense_keying.sv
// Bench for the radio data port: keying, transmit path, squelch, receive.
// Assumes shortened slot, lead and bit-length parameters set below.
`timescale 1ns/1ns
module test_radio_net_busy_sense_keying;
   import rnbsk_pkg::*;
   logic        mclk = 1'b0, air_clk = 1'b0, arst_n = 1'b0, key = 1'b0;
   logic        air_carrier = 1'b0, air_rx_data_mode = 1'b0, air_rx_chip = 1'b1;
   logic [23:0] word = 24'h7EA57E;
   rnbsk_cfg_t  cfg = '0;
   logic        dte_ptt, dte_tx_data, dte_tx_clock, dte_rx_data;
   logic        rx_data_clock_out, receive_squelch_n, air_tx_data, air_tx_en;
   logic [1:0]  rx_state;
   logic        if_err;
   int          err_total = 0, checks_done = 0, k1 = 0, ph = 0, r;
   always #25 mclk = ~mclk;
   initial begin
      #7;
      forever #32 air_clk = ~air_clk;
   end
   // Periodic chips: any 26-chip window holds k1 ones, whatever the phase
   always @(negedge air_clk) begin
      ph <= (ph == 25) ? 0 : ph + 1;
      air_rx_chip <= (ph < k1);
   end
   // Mid rates keep their full bit length: they only stretch the receive clock
   rnbsk_top #(.HALF_600(12), .HALF_16000(8), .SLOT_FH(20), .SLOT_SC(60), .LEAD_CYC(10))
      i_rnbsk_top (
      .mclk, .arst_n, .cfg, .dte_ptt, .dte_tx_data, .dte_tx_clock, .dte_rx_data,
      .rx_data_clock_out, .receive_squelch_n, .air_clk, .air_carrier,
      .air_rx_data_mode, .air_rx_chip, .air_tx_data, .air_tx_en);
   rnbsk_dte_model i_rnbsk_dte_model (.key, .word, .mclk, .dte_tx_clock, .receive_squelch_n,
      .rx_data_clock_out, .dte_ptt, .dte_tx_data, .rx_state, .if_err);
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected %0t %s", $time, m);
      end
   endtask : chk
   task automatic close_out;
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : close_out
   task automatic t_access(input logic t3, input logic fh, input int lo);
      int n;
      n = 0;
      @(negedge mclk);
      cfg = '{3'h4, fh, 1'b0, t3, 4'h1, 4'h0};
      key = 1'b1;
      while (dte_tx_clock === 1'b1 && n < 300) begin
         @(negedge mclk);
         n++;
      end
      chk(n >= lo && n <= lo + 8, 1'b1, "access delay");
      key = 1'b0;
      repeat (30) @(negedge mclk);
      $display("done access %0d", n);
   endtask : t_access
   task automatic t_tx;
      @(negedge mclk);
      cfg = '{3'h4, 1'b1, 1'b0, 1'b1, 4'h0, 4'h0};
      chk(receive_squelch_n, 1'b1, "busy before keying");
      key = 1'b1;
      air_rx_data_mode = 1'b1;
      air_carrier = 1'b1;
      for (int i = 23; i >= 0; i--) begin
         @(posedge dte_tx_clock);
         repeat (10) @(negedge mclk);
         chk({air_tx_data, air_tx_en, receive_squelch_n}, {word[i], 2'b11}, "air bit");
      end
      key = 1'b0;
      repeat (30) @(negedge mclk);
      chk({air_tx_en, air_tx_data, receive_squelch_n}, 3'b010, "after unkey");
      air_carrier = 1'b0;
      repeat (40) @(negedge mclk);
      $display("done transmit");
   endtask : t_tx
   task automatic t_rx(input logic [2:0] rate, input logic pt, input int k, input logic expd);
      int n;
      n = 0;
      @(negedge mclk);
      cfg = '{rate, 1'b1, pt, 1'b0, 4'h0, 4'h0};
      k1 = k;
      air_rx_data_mode = 1'b1;
      repeat (8) @(negedge mclk);
      air_carrier = 1'b1;
      while (receive_squelch_n === 1'b1 && n < 40) begin
         @(negedge mclk);
         n++;
      end
      chk(n < 10, 1'b1, "squelch late");
      n = 0;
      while (rx_data_clock_out === 1'b1 && n < 300) begin
         @(negedge mclk);
         n++;
      end
      chk((pt && rate == 3'h4) ? n < 8 : n >= 6 && n < 300, 1'b1, "clock lead");
      repeat (120) @(negedge mclk);
      chk(dte_rx_data, expd, "voted bit");
      chk(rx_state, 2'h2, "data status");
      air_carrier = 1'b0;
      repeat (40) @(negedge mclk);
      chk(receive_squelch_n, 1'b1, "squelch stuck");
      chk({rx_state, if_err}, 3'b000, "idle status");
      $display("done receive rate %0d", rate);
   endtask : t_rx
   task automatic t_voice;
      int lows;
      lows = 0;
      @(negedge mclk);
      air_rx_data_mode = 1'b0;
      air_carrier = 1'b1;
      for (int n = 0; n < 200; n++) begin
         @(negedge mclk);
         lows += (rx_data_clock_out !== 1'b1);
      end
      chk(receive_squelch_n, 1'b0, "voice squelch");
      chk(lows, 0, "voice clock");
      chk(rx_state, 2'h3, "voice status");
      air_carrier = 1'b0;
      repeat (40) @(negedge mclk);
      $display("done voice");
   endtask : t_voice
   // ----------------------------
   // Main sequence and watchdog
   // ----------------------------
   initial begin
      repeat (16) @(negedge mclk);
      chk({dte_tx_clock, dte_rx_data, rx_data_clock_out, receive_squelch_n,
           air_tx_data, air_tx_en}, 6'b111110, "reset levels");
      arst_n = 1'b1;
      repeat (4) @(negedge mclk);
      t_access(1'b1, 1'b1, 8);
      t_access(1'b0, 1'b1, 28);
      t_access(1'b0, 1'b0, 68);
      t_tx();
      for (r = 0; r < 5; r++) t_rx(r[2:0], 1'b0, 0, 1'b0);
      t_rx(3'h0, 1'b0, 13, 1'b0);
      t_rx(3'h0, 1'b0, 14, 1'b1);
      t_rx(3'h4, 1'b1, 26, 1'b1);
      t_voice();
      close_out();
   end
   // Whole run is a few thousand cycles
   initial begin
      repeat (40000) @(posedge mclk);
      err_total++;
      close_out();
   end
endmodule : test_radio_net_busy_sense_keying
